// *** sim/rstseq_chk.sv ***
/*
 * Checker of the reset sequencer: phase order, delay length, pin drive,
 * vector fetch and warning interrupt gating, seen at the top ports.
 * Assumes one clock, aclk, and the synchronous active-low aresetn.
 */
`timescale 1ns/1ps
`default_nettype none

module rstseq_chk #(
    parameter int SHORT_DELAY = 256,
    parameter int LONG_DELAY = 4096
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rst_pin_in_n,
    input wire logic rst_pin_oe_n,
    input wire rstseq_pkg::option_type option,
    input wire logic supply_low,
    input wire logic watchdog_underflow,
    input wire logic cpu_reset_n,
    input wire logic vector_fetch,
    input wire logic [15:0] vector_addr,
    input wire logic osc_run,
    input wire logic voltage_warning_irq,
    input wire rstseq_pkg::phase_type seq_phase
);
    import rstseq_pkg::*;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ----------
    // helper: cycles spent in the delay phase so far
    // ----------
    logic [12:0] dly_cnt_r;
    logic [12:0] dly_cnt_nxt;

    // cleared outside the delay, so a restart is measured from zero
    always_comb begin
        dly_cnt_nxt = (seq_phase == PH_DELAY) ? dly_cnt_r + 13'h1 : 13'h0;
    end

    always_ff @(posedge aclk) begin
        dly_cnt_r <= aresetn ? dly_cnt_nxt : 13'h0;
    end

    // ----------
    // sequences of the fetch step and of entry to run
    // ----------
    sequence s_fetch;
        vector_addr == 16'hFFFE ##1 vector_fetch && vector_addr == 16'hFFFF
            ##1 !vector_fetch;
    endsequence

    sequence s_enter_run;
        seq_phase == PH_RUN && $past(seq_phase) != PH_RUN;
    endsequence

    a_osc_running: assert property (osc_run)
        else $error("oscillator stopped");
    a_fetch_vector: assert property (
        $rose(vector_fetch) |-> s_fetch)
        else $error("vector fetch wrong");
    a_phase_order: assert property (s_enter_run |->
        $past(seq_phase, 2) == PH_FETCH && $past(seq_phase, 3) == PH_DELAY)
        else $error("run entered out of order");
    a_delay_pin_low: assert property (
        seq_phase == PH_DELAY |-> !rst_pin_oe_n)
        else $error("pin released in delay");
    a_delay_length: assert property (
        seq_phase == PH_FETCH && dly_cnt_r != 0
        |-> dly_cnt_r == (option.long_delay ? LONG_DELAY : SHORT_DELAY))
        else $error("delay length wrong");
    a_lowv_pin_held: assert property (supply_low && option.lvd_en
        |=> !rst_pin_oe_n)
        else $error("pin not held on low supply");
    a_wdog_min_width: assert property (watchdog_underflow
        |=> (!rst_pin_oe_n) [*8])
        else $error("watchdog pulse too short");
    a_pin_catch: assert property (
        !rst_pin_in_n && seq_phase == PH_RUN
        |=> seq_phase == PH_ACTIVE && !cpu_reset_n)
        else $error("pin reset missed");
    a_warn_gated: assert property (
        !option.lvd_en && !$past(option.lvd_en)
        |-> !voltage_warning_irq)
        else $error("warning irq without detector");

endmodule // rstseq_chk

bind reset_sequencer_voltage_monitor rstseq_chk #(
    .SHORT_DELAY(SHORT_DELAY),
    .LONG_DELAY(LONG_DELAY)
) u_chk (.*);

`default_nettype wire

// *** sim/supply_partner.sv ***
/*
 * Far side model: external reset circuitry on the open-drain pin and
 * the two supply comparators with hysteresis, driven by a vdd code.
 * Assumes the bench sets vdd and ext_pull after clock edges.
 */
`timescale 1ns/1ps
`default_nettype none

module supply_partner #(
    parameter int LVD_BASE = 40,
    parameter int AUX_GAP = 20,
    parameter int HYST = 4
) (
    input wire logic aclk,
    input wire logic rst_pin_oe_n,
    input wire logic ext_pull,
    input wire logic [7:0] vdd,
    input wire logic [1:0] detector_threshold,
    output logic rst_pin_in_n,
    output logic supply_low,
    output logic aux_supply_low
);
    int thr;

    // wired-and line; the weak pull-up wins only when nobody pulls
    assign rst_pin_in_n = !(ext_pull || !rst_pin_oe_n);

    // threshold follows the selected level
    always_comb begin
        thr = LVD_BASE + 8 * int'(detector_threshold);
    end

    // falling trip is lower than rising release to avoid chatter
    always_ff @(posedge aclk) begin
        if (vdd < thr - HYST) supply_low <= 1'b1;
        else if (vdd >= thr) supply_low <= 1'b0;
        if (vdd < thr + AUX_GAP - HYST) aux_supply_low <= 1'b1;
        else if (vdd >= thr + AUX_GAP) aux_supply_low <= 1'b0;
    end

endmodule // supply_partner

`default_nettype wire

// *** sim/tb_top.sv ***
/*
 * Self-checking bench of the reset sequencer: reset causes, delays,
 * vector fetch, cause flags, warning interrupts and register access.
 * Assumes supply_partner stands on the pin and comparator side.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rstseq_params.svh"

module tb_top;
    import rstseq_pkg::*;

    localparam int SD = 16;
    localparam int LD = 32;
    localparam logic [3:0] CS = `RSQ_OFF_CTRL_STAT;
    localparam logic [1:0] OK = `RSQ_RESP_OKAY;
    localparam logic [1:0] SE = `RSQ_RESP_SLVERR;

    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, rst_pin_in_n;
    logic rst_pin_out, rst_pin_oe_n, supply_low, aux_supply_low;
    logic watchdog_underflow, irq_service_entry, cpu_reset_n, osc_run;
    logic vector_fetch, detector_enable, voltage_warning_irq, ext_pull;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, detector_threshold;
    logic [15:0] vector_addr;
    logic [7:0] vdd;
    option_type option;
    phase_type seq_phase;
    int error_cnt, check_count;

    reset_sequencer_voltage_monitor #(
        .WDG_MIN_NS(40),
        .SHORT_DELAY(SD),
        .LONG_DELAY(LD)
    ) dut (.*);

    supply_partner u_sup (.aclk, .rst_pin_oe_n, .ext_pull, .vdd,
        .detector_threshold, .rst_pin_in_n, .supply_low, .aux_supply_low);

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = !aclk;
    end

    // ----------
    // shared tasks
    // ----------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask

    // follow a sequence to run: delay count, fetched addresses, release
    task automatic seq(input int ed);
        int n, d;
        logic [15:0] va [$];
        n = 0;
        d = 0;
        do begin
            @(posedge aclk);
            n++;
            d += (seq_phase === PH_DELAY);
            if (vector_fetch === 1'b1) va.push_back(vector_addr);
        end while (seq_phase !== PH_RUN && n < 9999);
        chk(d, ed);
        chk(va.size(), 2);
        chk({va[0], va[1]}, 32'hFFFEFFFF);
        cyc(1);
        chk({cpu_reset_n, osc_run}, 2'h3);
    endtask

    task automatic boot(input option_type o, input logic [7:0] v,
                        input int ed);
        option <= o;
        aresetn <= 1'b0;
        cyc(6);
        aresetn <= 1'b1;
        vdd <= v;
        seq(ed);
    endtask

    task automatic serve;
        irq_service_entry <= 1'b1;
        cyc(1);
        irq_service_entry <= 1'b0;
        cyc(2);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------
    // scenarios
    // ----------
    task automatic t_regs;
        rd(4'h4, 32'h60, OK);
        chk({detector_enable, detector_threshold}, 3'h5);
        wr(CS, 32'h20, OK);
        rd(CS, 32'h0, OK);
        wr(4'h8, 32'hFF, SE);
        rd(4'h8, 32'h0, SE);
        $display("register test done");
    endtask

    task automatic t_pin;
        ext_pull <= 1'b1;
        cyc(3);
        chk({seq_phase, cpu_reset_n}, {PH_ACTIVE, 1'b0});
        ext_pull <= 1'b0;
        seq(SD);
        rd(CS, 32'h0, OK);
        $display("pin test done");
    endtask

    task automatic t_wdog;
        int n;
        n = 0;
        watchdog_underflow <= 1'b1;
        cyc(1);
        watchdog_underflow <= 1'b0;
        do begin
            @(posedge aclk);
            n += !rst_pin_oe_n;
        end while (!rst_pin_oe_n && n < 99);
        chk(n >= 8, 1'b1);
        seq(SD);
        rd(CS, 32'h1, OK);
        $display("watchdog test done");
    endtask

    task automatic t_lowv;
        int n;
        n = 0;
        vdd <= 8'd30;
        cyc(5);
        chk({seq_phase, rst_pin_oe_n}, {PH_ACTIVE, 1'b0});
        chk(rst_pin_out, 1'b0);
        vdd <= 8'd100;
        do @(posedge aclk); while (seq_phase !== PH_DELAY && ++n < 99);
        cyc(2);
        vdd <= 8'd30;
        cyc(3);
        chk(seq_phase, PH_ACTIVE);
        vdd <= 8'd100;
        seq(SD);
        rd(CS, 32'h10, OK);
        wr(CS, 32'h0, OK);
        rd(CS, 32'h0, OK);
        $display("low voltage test done");
    endtask

    task automatic t_irq;
        wr(CS, 32'h40, OK);
        cyc(2);
        chk(voltage_warning_irq, 1'b1);
        serve;
        cyc(8);
        chk(voltage_warning_irq, 1'b0);
        vdd <= 8'd58;
        cyc(4);
        chk(voltage_warning_irq, 1'b1);
        rd(CS, 32'h60, OK);
        serve;
        wr(CS, 32'h0, OK);
        wr(CS, 32'h40, OK);
        cyc(2);
        chk(voltage_warning_irq, 1'b1);
        serve;
        vdd <= 8'd100;
        cyc(4);
        chk(voltage_warning_irq, 1'b1);
        serve;
        chk(voltage_warning_irq, 1'b0);
        $display("interrupt test done");
    endtask

    task automatic t_quiet;
        // armed interrupt is disarmed by a low-voltage reset and reads low after it
        vdd <= 8'h1E;
        cyc(4);
        vdd <= 8'h64;
        seq(SD);
        chk(voltage_warning_irq, 1'b0);
        boot(4'h2, 8'd100, SD);
        wr(CS, 32'h40, OK);
        vdd <= 8'd30;
        cyc(6);
        chk({seq_phase, voltage_warning_irq}, {PH_RUN, 1'b0});
        boot(4'hD, 8'd100, LD);
        chk(detector_threshold, 2'h2);
        $display("gating and long delay test done");
    endtask

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, ext_pull} = 3'h0;
        {watchdog_underflow, irq_service_entry} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        s_axi_wstrb = 4'hF;
        option = 4'hA;
        vdd = 8'd100;
        aresetn = 1'b0;
        error_cnt = 0;
        check_count = 0;
        boot(4'hA, 8'd100, SD);
        t_regs;
        t_pin;
        t_wdog;
        t_lowv;
        t_irq;
        t_quiet;
        conclude;
    end

    // the whole run needs a few hundred cycles; this cuts a hang
    initial begin
        #250000;
        error_cnt++;
        conclude;
    end

endmodule // tb_top

`default_nettype wire

// *** src/reset_sequencer_voltage_monitor.sv ***
/*
 * Reset sequencer with low-voltage reset and voltage-warning logic.
 * Merges pin, low-voltage and watchdog causes, drives the open-drain
 * reset pin, times the stabilisation delay and the vector fetch, and
 * turns the auxiliary comparator into a flag and toggle interrupts.
 * Assumes a single 200 MHz clock, comparators synchronous to it, and an
 * AXI4-Lite master with one write and one read outstanding at most.
 */
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "rstseq_params.svh"

// Behaviour
// RULE1 - pin, low-voltage and watchdog causes drive pin
// RULE2 - active phase, then delay, then vector fetch
// RULE3 - delay is 256 or 4096 clocks by option
// RULE4 - vector fetch lasts exactly two cycles
// RULE5 - vector taken from top two memory bytes
// RULE6 - oscillator keeps running throughout reset
// RULE7 - pin is input and open-drain output
// RULE8 - pin pulse caught without a running clock
// RULE9 - low supply holds the reset pin low
// RULE10 - watchdog underflow drives pin for minimum width
// RULE11 - low-voltage detector optional, threshold selectable
// RULE12 - warning logic works only with detector enabled
// RULE13 - warning flag is read-only real-time comparator
// RULE14 - enabled interrupt on every warning flag toggle
// RULE15 - no warning interrupt during reset delay
// RULE16 - enabling early gives two interrupts on rise
// RULE17 - enabling after threshold gives one interrupt
// RULE18 - pending interrupt cleared at service entry
// RULE19 - two cause flags, cleared by writing zero
// RULE20 - delay starts at release, restarts on reassert
module reset_sequencer_voltage_monitor #(
    parameter int WDG_MIN_NS = `RSQ_WDG_MIN_NS,
    parameter int SHORT_DELAY = `RSQ_SHORT_DELAY,
    parameter int LONG_DELAY = `RSQ_LONG_DELAY
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [`RSQ_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`RSQ_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // reset pin, open drain
    input wire logic rst_pin_in_n,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    // causes and comparators
    input wire rstseq_pkg::option_type option,
    input wire logic supply_low,
    input wire logic aux_supply_low,
    input wire logic watchdog_underflow,
    input wire logic irq_service_entry,
    // towards core, oscillator and analog block
    output logic cpu_reset_n,
    output logic vector_fetch,
    output logic [15:0] vector_addr,
    output logic osc_run,
    output logic detector_enable,
    output logic [1:0] detector_threshold,
    output logic voltage_warning_irq,
    output rstseq_pkg::phase_type seq_phase
);
    import rstseq_pkg::*;

    // ----------
    // derived timing and elaboration checks
    // ----------
    localparam int WDG_CYC =
        (WDG_MIN_NS * 1000 + `RSQ_CLK_PERIOD_PS - 1) / `RSQ_CLK_PERIOD_PS;

    if (WDG_CYC < 1 || WDG_CYC > 255) begin : g_bad_wdg
        $error("reset_sequencer_voltage_monitor: watchdog width range");
    end

    localparam logic [7:0] WDG_LOAD = 8'(WDG_CYC);

    seq_state_type s_r;
    seq_state_type s_nxt;
    logic ext_catch_r;
    logic delay_done;
    logic low_eff;
    logic any_cause;
    logic wr_go;
    logic wr_hit;
    logic en_rise;
    logic toggle;
    logic [31:0] ctrl_word;
    logic [31:0] seq_word;

    // ----------
    // external pulse catch
    // ----------
    // set straight from the pin so a pulse is seen with the clock
    // stopped in halt; released only once the pin reads high again
    always_ff @(posedge aclk or negedge rst_pin_in_n) begin
        if (!rst_pin_in_n) begin
            ext_catch_r <= 1'b1; // [RULE8] [RULE7]
        end else begin
            ext_catch_r <= 1'b0;
        end
    end

    // ----------
    // stabilisation delay
    // ----------
    stab_delay_timer #(
        .SHORT_DELAY(SHORT_DELAY),
        .LONG_DELAY(LONG_DELAY)
    ) u_delay (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(s_r.phase == PH_DELAY),
        .long_sel(option.long_delay),
        .done(delay_done)
    );

    // ----------
    // register read words
    // ----------
    // bit 3 and everything not named reads as zero
    always_comb begin
        ctrl_word = 32'h0;
        ctrl_word[`RSQ_BIT_IRQ_EN] = s_r.irq_en;
        ctrl_word[`RSQ_BIT_WARN] = s_r.warn; // [RULE13]
        ctrl_word[`RSQ_BIT_LOWV_CF] = s_r.lowv_cf;
        ctrl_word[`RSQ_BIT_WDOG_CF] = s_r.wdog_cf;
        seq_word = 32'h0;
        seq_word[`RSQ_POS_PHASE +: 3] = s_r.phase;
        seq_word[`RSQ_BIT_IRQ_PEND] = s_r.irq_pend;
        seq_word[`RSQ_BIT_OPT_LOWV] = s_r.lvd_en;
        seq_word[`RSQ_POS_OPT_THR +: 2] = s_r.lvd_thr;
        seq_word[`RSQ_BIT_OPT_LONG] = option.long_delay;
    end

    // ----------
    // next state
    // ----------
    always_comb begin
        s_nxt = s_r;
        low_eff = option.lvd_en && supply_low; // [RULE11] [RULE9]
        any_cause = low_eff || watchdog_underflow;
        wr_go = s_r.awready && s_r.wready;
        wr_hit = wr_go && s_axi_wstrb[0]
            && (s_axi_awaddr == `RSQ_OFF_CTRL_STAT);
        en_rise = 1'b0;
        toggle = 1'b0;
        s_nxt.fetch_valid = 1'b0;
        s_nxt.osc_run = 1'b1; // [RULE6]
        s_nxt.lvd_en = option.lvd_en;
        s_nxt.lvd_thr = option.lvd_thr; // [RULE11]

        // watchdog stretch: pin held for the full minimum width
        if (watchdog_underflow) begin
            s_nxt.wd_cnt = WDG_LOAD; // [RULE10]
        end else if (s_r.wd_cnt != 8'h0) begin
            s_nxt.wd_cnt = 8'(s_r.wd_cnt - 8'h1);
        end

        // phase sequence
        case (s_r.phase)
            PH_RUN: begin
                if (any_cause || ext_catch_r) begin
                    s_nxt.phase = PH_ACTIVE; // [RULE1]
                end
            end
            PH_ACTIVE: begin
                // wait for our own drive to be gone and the pin high
                if (!any_cause && s_r.wd_cnt == 8'h0 && !s_r.drive
                        && !ext_catch_r) begin
                    s_nxt.phase = PH_DELAY; // [RULE2] [RULE20]
                end
            end
            PH_DELAY: begin
                if (any_cause) begin
                    s_nxt.phase = PH_ACTIVE; // [RULE20]
                end else if (delay_done) begin
                    s_nxt.phase = PH_FETCH; // [RULE2] [RULE3]
                    s_nxt.fetch_idx = 1'b0;
                end
            end
            PH_FETCH: begin
                // two fetch cycles, low byte address then high [RULE5]
                s_nxt.fetch_valid = 1'b1;
                s_nxt.fetch_addr = 16'(`RSQ_VECTOR_LO + 16'(s_r.fetch_idx));
                s_nxt.fetch_idx = 1'b1;
                if (s_r.fetch_idx) begin
                    s_nxt.phase = PH_RUN; // [RULE4]
                end
                if (any_cause) begin
                    s_nxt.phase = PH_ACTIVE;
                    s_nxt.fetch_valid = 1'b0;
                end
            end
            default: begin
                s_nxt.phase = PH_ACTIVE;
            end
        endcase

        // pin drive: internal causes in the active phase, always in delay
        s_nxt.drive = low_eff || (s_nxt.wd_cnt != 8'h0)
            || (s_nxt.phase == PH_DELAY); // [RULE1] [RULE9] [RULE10]
        s_nxt.cpu_reset_n = (s_nxt.phase == PH_RUN);

        // cause flags: software writes zero to clear, hardware set wins
        if (wr_hit && !s_axi_wdata[`RSQ_BIT_LOWV_CF]) begin
            s_nxt.lowv_cf = 1'b0; // [RULE19]
        end
        if (wr_hit && !s_axi_wdata[`RSQ_BIT_WDOG_CF]) begin
            s_nxt.wdog_cf = 1'b0; // [RULE19]
        end
        if (watchdog_underflow) begin
            s_nxt.wdog_cf = 1'b1; // [RULE19]
        end
        if (low_eff) begin
            s_nxt.lowv_cf = 1'b1; // [RULE19]
            s_nxt.wdog_cf = 1'b0;
        end

        // warning flag follows the comparator only with detector on
        s_nxt.warn = option.lvd_en && aux_supply_low; // [RULE12] [RULE13]
        toggle = (s_nxt.warn != s_r.warn);

        // enable bit; setting it raises one interrupt by itself
        if (wr_hit) begin
            s_nxt.irq_en = s_axi_wdata[`RSQ_BIT_IRQ_EN];
            en_rise = s_axi_wdata[`RSQ_BIT_IRQ_EN] && !s_r.irq_en;
        end

        // pending: service entry clears, a new event in that cycle wins
        if (irq_service_entry) begin
            s_nxt.irq_pend = 1'b0; // [RULE18]
        end
        if (en_rise || (toggle && s_r.irq_en)) begin
            s_nxt.irq_pend = 1'b1; // [RULE14] [RULE16] [RULE17]
        end

        // any reset phase disarms the interrupt, so a crossing inside
        // the delay can never be reported
        if (s_r.phase != PH_RUN || !option.lvd_en) begin
            s_nxt.irq_en = 1'b0; // [RULE15] [RULE12]
            s_nxt.irq_pend = 1'b0;
        end

        // write channel: take address and data together, then answer
        s_nxt.awready = s_axi_awvalid && s_axi_wvalid && !s_r.awready
            && !s_r.bvalid;
        s_nxt.wready = s_nxt.awready;
        if (wr_go) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = (s_axi_awaddr == `RSQ_OFF_CTRL_STAT
                || s_axi_awaddr == `RSQ_OFF_SEQ_STAT)
                ? `RSQ_RESP_OKAY : `RSQ_RESP_SLVERR;
        end else if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // read channel: one cycle of arready, data on the next edge
        s_nxt.arready = s_axi_arvalid && !s_r.arready && !s_r.rvalid;
        if (s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            case (s_axi_araddr)
                `RSQ_OFF_CTRL_STAT: begin
                    s_nxt.rdata = ctrl_word;
                    s_nxt.rresp = `RSQ_RESP_OKAY;
                end
                `RSQ_OFF_SEQ_STAT: begin
                    s_nxt.rdata = seq_word;
                    s_nxt.rresp = `RSQ_RESP_OKAY;
                end
                default: begin
                    s_nxt.rdata = 32'h0;
                    s_nxt.rresp = `RSQ_RESP_SLVERR;
                end
            endcase
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    // ----------
    // state register
    // ----------
    // power-up starts in the active phase, so the core sees a full
    // sequence even without any external reset circuit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.phase <= PH_ACTIVE;
            s_r.drive <= 1'b1;
            s_r.osc_run <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------
    // outputs, all but the constant rst_pin_out straight from the state register
    // ----------
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rresp = s_r.rresp;
    assign s_axi_rdata = s_r.rdata;
    assign rst_pin_out = 1'b0; // open drain only ever pulls low [RULE7]
    assign rst_pin_oe_n = !s_r.drive;
    assign cpu_reset_n = s_r.cpu_reset_n;
    assign vector_fetch = s_r.fetch_valid;
    assign vector_addr = s_r.fetch_addr;
    assign osc_run = s_r.osc_run;
    assign detector_enable = s_r.lvd_en;
    assign detector_threshold = s_r.lvd_thr;
    assign voltage_warning_irq = s_r.irq_pend;
    assign seq_phase = s_r.phase;

endmodule // reset_sequencer_voltage_monitor
`default_nettype wire

// *** src/rstseq_params.svh ***
/*
 * Named constants of the reset sequencer and supply monitor: register
 * offsets, field positions, the reset vector and timing figures.
 * Assumes a 200 MHz clock and an AXI4-Lite bus with 32-bit data.
 */
`ifndef RSTSEQ_PARAMS_SVH
`define RSTSEQ_PARAMS_SVH

// ----------
// timing
// ----------
`define RSQ_CLK_PERIOD_PS 5000
`define RSQ_WDG_MIN_NS 500
`define RSQ_SHORT_DELAY 256
`define RSQ_LONG_DELAY 4096
`define RSQ_FETCH_CYCLES 2

// ----------
// reset vector location
// ----------
`define RSQ_VECTOR_LO 16'hFFFE

// ----------
// register map (byte addresses)
// ----------
`define RSQ_ADDR_W 4
`define RSQ_OFF_CTRL_STAT 4'h0
`define RSQ_OFF_SEQ_STAT 4'h4

// control/status register fields
`define RSQ_BIT_IRQ_EN 6
`define RSQ_BIT_WARN 5
`define RSQ_BIT_LOWV_CF 4
`define RSQ_BIT_WDOG_CF 0

// sequence status register fields
`define RSQ_POS_PHASE 0
`define RSQ_BIT_IRQ_PEND 4
`define RSQ_BIT_OPT_LOWV 5
`define RSQ_POS_OPT_THR 6
`define RSQ_BIT_OPT_LONG 8

// ----------
// bus answers
// ----------
`define RSQ_RESP_OKAY 2'h0
`define RSQ_RESP_SLVERR 2'h2

`endif

// *** src/rstseq_pkg.sv ***
/*
 * Types shared by the reset sequencer and its delay timer.
 * Assumes rstseq_params.svh supplies the numeric constants.
 */
package rstseq_pkg;

    // sequence phase
    typedef enum logic [2:0] {
        PH_RUN = 3'b000,
        PH_ACTIVE = 3'b001,
        PH_DELAY = 3'b010,
        PH_FETCH = 3'b011
    } phase_type;

    // non-volatile option setting, static while running
    typedef struct packed {
        logic lvd_en;
        logic [1:0] lvd_thr;
        logic long_delay;
    } option_type;

    // state of the stabilisation delay timer
    typedef struct packed {
        logic [12:0] cnt;
        logic done;
    } timer_state_type;

    // whole state of the sequencer
    typedef struct packed {
        phase_type phase;
        logic [7:0] wd_cnt;
        logic drive;
        logic fetch_idx;
        logic fetch_valid;
        logic [15:0] fetch_addr;
        logic cpu_reset_n;
        logic osc_run;
        logic [1:0] lvd_thr;
        logic lvd_en;
        logic warn;
        logic irq_en;
        logic irq_pend;
        logic lowv_cf;
        logic wdog_cf;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } seq_state_type;

endpackage

// *** src/stab_delay_timer.sv ***
/*
 * Stabilisation delay timer: counts clocks while run is high and pulses
 * done in the last cycle of a 256 or 4096 cycle delay.
 * Assumes run drops for at least one cycle between two delays.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rstseq_params.svh"

module stab_delay_timer #(
    parameter int SHORT_DELAY = `RSQ_SHORT_DELAY,
    parameter int LONG_DELAY = `RSQ_LONG_DELAY
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic long_sel,
    output logic done
);
    import rstseq_pkg::*;

    // ----------
    // elaboration checks
    // ----------
    if (SHORT_DELAY < 2 || LONG_DELAY < SHORT_DELAY
            || LONG_DELAY > 8192) begin : g_bad
        $error("stab_delay_timer: delay lengths out of range");
    end

    localparam logic [12:0] SHORT_LAST = 13'(SHORT_DELAY - 2);
    localparam logic [12:0] LONG_LAST = 13'(LONG_DELAY - 2);

    timer_state_type s_r;
    timer_state_type s_nxt;
    logic [12:0] last;

    // ----------
    // counter
    // ----------
    // dropping run restarts the count, so a reasserted cause costs a
    // full delay again [RULE20]
    always_comb begin
        last = long_sel ? LONG_LAST : SHORT_LAST; // [RULE3]
        s_nxt.cnt = run ? 13'(s_r.cnt + 13'h1) : 13'h0;
        s_nxt.done = run && (s_r.cnt == last);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;

endmodule // stab_delay_timer
`default_nettype wire
